// file: gpio_pin_config_bank_regs.svh
// register indices, field positions, reset values and masks of the pin bank
`ifndef GPIO_PIN_CONFIG_BANK_REGS_SVH
`define GPIO_PIN_CONFIG_BANK_REGS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define GPIO_1_5_CONFIG_IDX 8'h28
`define GPIO_1_6_CONFIG_IDX 8'h29
`define GPIO_1_7_CONFIG_IDX 8'h2A
`define GPIO_2_0_CONFIG_IDX 8'h2B
`define GPIO_2_1_CONFIG_IDX 8'h2C
`define GPIO_2_2_CONFIG_IDX 8'h2D
`define GPIO_2_4_CONFIG_IDX 8'h2F
`define GPIO_2_5_CONFIG_IDX 8'h30
`define GPIO_DATA_IDX       8'h40
`define GPIO_STATUS_IDX     8'h41
`define GPIO_MASK_IDX       8'h42

// ----------------------------------------------------------------
// configuration fields
// ----------------------------------------------------------------
`define CFG_DIR_BIT     0
`define CFG_POL_BIT     1
`define CFG_ALT_BIT     2
`define CFG_ALT_HI_BIT  3
`define CFG_ODRAIN_BIT  7
`define CFG_RESET       8'h01
`define CFG_WMASK_ONE   8'h87
`define CFG_WMASK_TWO   8'h8F
`define CFG_WMASK_NONE  8'h83

// ----------------------------------------------------------------
// alternate select codes of two-bit fields
// ----------------------------------------------------------------
`define ALT_GPIO  2'h0
`define ALT_KBC   2'h1
`define ALT_SEL_B 2'h2
`define ALT_SEL_C 2'h3

// ----------------------------------------------------------------
// status and mask bits
// ----------------------------------------------------------------
`define STAT_EDGE0_BIT 0
`define STAT_EDGE1_BIT 1
`define STAT_WIDTH     2

`endif

// file: gpio_pin_pkg.sv
// types shared by the pin configuration bank
package gpio_pin_pkg;

  // signals driven by the alternate-function units into the bank
  typedef struct packed {
    logic kbc_port_bit7;
    logic kbc_port_bit6;
    logic kbc_port_bit2;
    logic floppy_drive_select_1_n;
    logic floppy_motor_select_1_n;
  } unit_drive_s;

  // pin levels handed to the alternate-function units
  typedef struct packed {
    logic joystick1_y_axis;
    logic joystick2_x_axis;
    logic joystick2_y_axis;
    logic kbc_port_bit7;
    logic kbc_port_bit6;
    logic kbc_port_bit2;
    logic interrupt_request_6_input;
    logic music_serial_receive;
  } unit_sense_s;

  typedef logic [7:0] cfg_t;

endpackage

// file: gpio_pin_config_bank.sv
// pin configuration bank: per-pin direction, polarity, driver, alt routing
`timescale 1ns/100ps
`include "gpio_pin_config_bank_regs.svh"

module gpio_pin_config_bank
  import gpio_pin_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [7:0]            pad_in,
  output logic      [7:0]            pad_out,
  output logic      [7:0]            pad_oe,
  input  wire unit_drive_s           unit_drive,
  output unit_sense_s                unit_sense,
  output logic                       irq
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (ADDR_WIDTH < 10 || ADDR_WIDTH > 32) begin : g_bad_width
    $error("ADDR_WIDTH must lie between 10 and 32");
  end

  // pin slots: 0=1.5 1=1.6 2=1.7 3=2.0 4=2.1 5=2.2 6=2.4 7=2.5
  localparam logic [7:0] CFG_IDX [0:7] = '{
    `GPIO_1_5_CONFIG_IDX, `GPIO_1_6_CONFIG_IDX, `GPIO_1_7_CONFIG_IDX,
    `GPIO_2_0_CONFIG_IDX, `GPIO_2_1_CONFIG_IDX, `GPIO_2_2_CONFIG_IDX,
    `GPIO_2_4_CONFIG_IDX, `GPIO_2_5_CONFIG_IDX};
  // reserved bits are not stored, so they read back as zero
  localparam logic [7:0] CFG_WMASK [0:7] = '{
    `CFG_WMASK_ONE, `CFG_WMASK_ONE, `CFG_WMASK_ONE,
    `CFG_WMASK_TWO, `CFG_WMASK_TWO, `CFG_WMASK_TWO,
    `CFG_WMASK_NONE, `CFG_WMASK_ONE};

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cfg_t                   cfg [0:7];
  logic [7:0]             gpio_data;
  logic [7:0]             pin_in;
  logic [7:0]             pin_prev;
  logic [`STAT_WIDTH-1:0] status;
  logic [`STAT_WIDTH-1:0] mask;
  logic                   first_cycle;
  // per-pin fields, declared early since the read mux uses them
  logic [7:0]             dir_vec;
  logic [7:0]             pol_vec;
  logic [7:0]             od_vec;
  logic [7:0]             sel1_vec;
  logic [1:0]             sel20;
  logic [1:0]             sel21;
  logic [1:0]             sel22;
  logic [7:0]             val_in;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic [7:0]  cfg_hit;
  logic        data_hit;
  logic        stat_hit;
  logic        mask_hit;
  logic        any_hit;
  logic        access;
  logic        commit;
  logic        wr_commit;
  logic        rd_commit;
  logic [31:0] rd_data;
  logic [7:0]  cfg_rd;

  for (genvar i = 0; i < 8; i++) begin : g_dec
    assign cfg_hit[i] = paddr == ADDR_WIDTH'({CFG_IDX[i], 2'b00});
  end
  assign data_hit  = paddr == ADDR_WIDTH'({`GPIO_DATA_IDX, 2'b00});
  assign stat_hit  = paddr == ADDR_WIDTH'({`GPIO_STATUS_IDX, 2'b00});
  assign mask_hit  = paddr == ADDR_WIDTH'({`GPIO_MASK_IDX, 2'b00});
  assign any_hit   = |cfg_hit | data_hit | stat_hit | mask_hit;
  // one wait state keeps prdata and pready straight from flops
  assign access    = psel & penable & ~pready;
  assign commit    = psel & penable & pready;
  assign wr_commit = commit & pwrite & any_hit;
  assign rd_commit = commit & ~pwrite;

  always_comb begin
    cfg_rd = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (cfg_hit[i]) begin
        cfg_rd = cfg[i];
      end
    end
  end

  assign rd_data = data_hit ? {24'h0, pin_in ^ pol_vec}
                 : stat_hit ? {{(32-`STAT_WIDTH){1'b0}}, status}
                 : mask_hit ? {{(32-`STAT_WIDTH){1'b0}}, mask}
                 : {24'h0, cfg_rd};

  // ----------------------------------------------------------------
  // per-pin fields
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 8; i++) begin : g_fld
    assign dir_vec[i]  = cfg[i][`CFG_DIR_BIT];
    assign pol_vec[i]  = cfg[i][`CFG_POL_BIT];
    assign od_vec[i]   = cfg[i][`CFG_ODRAIN_BIT];
    assign sel1_vec[i] = cfg[i][`CFG_ALT_BIT];
  end
  assign sel20  = cfg[3][`CFG_ALT_HI_BIT:`CFG_ALT_BIT];
  assign sel21  = cfg[4][`CFG_ALT_HI_BIT:`CFG_ALT_BIT];
  assign sel22  = cfg[5][`CFG_ALT_HI_BIT:`CFG_ALT_BIT];
  assign val_in = pin_in ^ pol_vec;

  // ----------------------------------------------------------------
  // output source per pin
  // ----------------------------------------------------------------
  logic [7:0] out_src;
  logic [7:0] drive_lvl;
  logic [7:0] next_pad_out;
  logic [7:0] next_pad_oe;

  assign out_src[3] = sel20 == `ALT_KBC   ? unit_drive.kbc_port_bit7
                    : sel20 == `ALT_SEL_B ? unit_drive.floppy_drive_select_1_n
                    : gpio_data[3];
  assign out_src[4] = sel21 == `ALT_KBC ? unit_drive.kbc_port_bit6
                    : gpio_data[4];
  assign out_src[5] = sel22 == `ALT_KBC   ? unit_drive.kbc_port_bit2
                    : sel22 == `ALT_SEL_C ? unit_drive.floppy_motor_select_1_n
                    : gpio_data[5];
  // pin 2.4 is plain gpio only
  assign out_src[6] = gpio_data[6];
  assign out_src[2:0] = gpio_data[2:0];
  assign out_src[7]   = gpio_data[7];

  // invert on the way out too
  assign drive_lvl    = out_src ^ pol_vec;
  // open drain only ever pulls low
  assign next_pad_out = drive_lvl & ~od_vec;
  // outputs only when direction is zero
  assign next_pad_oe  = ~dir_vec & (~od_vec | ~drive_lvl);

  // ----------------------------------------------------------------
  // routing to the units
  // ----------------------------------------------------------------
  unit_sense_s next_sense;
  logic [`STAT_WIDTH-1:0] edge_set;

  always_comb begin
    next_sense.joystick1_y_axis = sel1_vec[0] & val_in[0];
    next_sense.joystick2_x_axis = sel1_vec[1] & val_in[1];
    next_sense.joystick2_y_axis = sel1_vec[2] & val_in[2];
    next_sense.kbc_port_bit7 = sel20 == `ALT_KBC ? val_in[3] : 1'b1;
    next_sense.kbc_port_bit6 = sel21 == `ALT_KBC ? val_in[4] : 1'b1;
    next_sense.interrupt_request_6_input =
      sel21 == `ALT_SEL_C ? val_in[4] : 1'b0;
    next_sense.kbc_port_bit2 = sel22 == `ALT_KBC ? val_in[5] : 1'b1;
    // music receive, idle high like a serial line
    next_sense.music_serial_receive = sel1_vec[7] ? val_in[7] : 1'b1;
  end

  // either-edge input 0 on pin 2.1
  assign edge_set[`STAT_EDGE0_BIT] =
    (sel21 == `ALT_SEL_B) & (pin_in[4] ^ pin_prev[4]);
  // either-edge input 1 on pin 2.2
  assign edge_set[`STAT_EDGE1_BIT] =
    (sel22 == `ALT_SEL_B) & (pin_in[5] ^ pin_prev[5]);

  // set wins over the read clear
  logic [`STAT_WIDTH-1:0] next_status;
  assign next_status = (status & ~{`STAT_WIDTH{rd_commit & stat_hit}})
                     | edge_set;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        cfg[i] <= `CFG_RESET;
      end
    end else if (wr_commit) begin
      for (int i = 0; i < 8; i++) begin
        if (cfg_hit[i]) begin
          cfg[i] <= pwdata[7:0] & CFG_WMASK[i];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_data <= 8'h00;
      mask      <= '0;
    end else begin
      if (wr_commit && data_hit) begin
        gpio_data <= pwdata[7:0];
      end
      if (wr_commit && mask_hit) begin
        mask <= pwdata[`STAT_WIDTH-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= access;
      prdata  <= (access && !pwrite && any_hit) ? rd_data : 32'h0000_0000;
      pslverr <= access & ~any_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_in      <= 8'h00;
      pin_prev    <= 8'h00;
      status      <= '0;
      irq         <= 1'b0;
      pad_out     <= 8'h00;
      pad_oe      <= 8'h00;
      unit_sense  <= '0;
      first_cycle <= 1'b1;
    end else begin
      pin_in      <= pad_in;
      pin_prev    <= pin_in;
      status      <= next_status;
      irq         <= |(next_status & mask);
      pad_out     <= next_pad_out;
      pad_oe      <= next_pad_oe;
      unit_sense  <= next_sense;
      first_cycle <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_DIR_INPUT: assert property (
    @(posedge pclk) disable iff (!presetn)
    cfg[6][`CFG_DIR_BIT] |=> !pad_oe[6])
    else $error("input pin is driven");

  AST_POL_OUT: assert property (
    @(posedge pclk) disable iff (!presetn)
    !cfg[6][`CFG_DIR_BIT] && !cfg[6][`CFG_ODRAIN_BIT]
    |=> pad_oe[6] && pad_out[6] == ($past(gpio_data[6]) ^ $past(pol_vec[6])))
    else $error("push-pull output level wrong");

  AST_OPEN_DRAIN: assert property (
    @(posedge pclk) disable iff (!presetn)
    !cfg[6][`CFG_DIR_BIT] && cfg[6][`CFG_ODRAIN_BIT]
    |=> !pad_out[6] && pad_oe[6] == !$past(drive_lvl[6]))
    else $error("open drain drove high");

  AST_RESET_VAL: assert property (
    @(posedge pclk) disable iff (!presetn)
    first_cycle |-> cfg[0] == 8'h01 && cfg[3] == 8'h01 && cfg[6] == 8'h01)
    else $error("config not at reset value");

  AST_JOY1Y: assert property (
    @(posedge pclk) disable iff (!presetn)
    sel1_vec[0] ##1 sel1_vec[0]
    |-> unit_sense.joystick1_y_axis == $past(val_in[0]))
    else $error("joystick route wrong");

  AST_DS1: assert property (
    @(posedge pclk) disable iff (!presetn)
    sel20 == `ALT_SEL_B && !cfg[3][`CFG_DIR_BIT] && !od_vec[3]
    |=> pad_out[3] ==
        ($past(unit_drive.floppy_drive_select_1_n) ^ $past(pol_vec[3])))
    else $error("drive select not on pin");

  AST_INTERRUPT_REQUEST_6_INPUT: assert property (
    @(posedge pclk) disable iff (!presetn)
    sel21 != `ALT_SEL_C |=> !unit_sense.interrupt_request_6_input)
    else $error("interrupt_request_6_input passed while not selected");

  AST_EDGE1: assert property (
    @(posedge pclk) disable iff (!presetn)
    sel22 == `ALT_SEL_B && $changed(pin_in[5])
    |=> status[`STAT_EDGE1_BIT])
    else $error("edge not latched");

  AST_RESERVED: assert property (
    @(posedge pclk) disable iff (!presetn)
    commit && !pwrite && cfg_hit[0] |-> prdata[6:3] == 4'h0)
    else $error("reserved bits read nonzero");

  AST_MIDI: assert property (
    @(posedge pclk) disable iff (!presetn)
    !sel1_vec[7] |=> unit_sense.music_serial_receive)
    else $error("music receive not idle");

  AST_PLAIN: assert property (
    @(posedge pclk) disable iff (!presetn)
    cfg[6][`CFG_ALT_HI_BIT:`CFG_ALT_BIT] == 2'b00)
    else $error("pin 2.4 holds select bits");

  AST_JOY2X: assert property (
    @(posedge pclk) disable iff (!presetn)
    sel1_vec[1] ##1 sel1_vec[1]
    |-> unit_sense.joystick2_x_axis == $past(val_in[1]))
    else $error("joystick 2 x route wrong");

  AST_JOY2Y: assert property (
    @(posedge pclk) disable iff (!presetn)
    sel1_vec[2] ##1 sel1_vec[2]
    |-> unit_sense.joystick2_y_axis == $past(val_in[2]))
    else $error("joystick 2 y route wrong");

  AST_KBC6_OUT: assert property (
    @(posedge pclk) disable iff (!presetn)
    sel21 == `ALT_KBC && !dir_vec[4] && !od_vec[4]
    |=> pad_out[4] == ($past(unit_drive.kbc_port_bit6) ^ $past(pol_vec[4])))
    else $error("kbc bit 6 not on pin");

  AST_EDGE0: assert property (
    @(posedge pclk) disable iff (!presetn)
    sel21 == `ALT_SEL_B && $changed(pin_in[4])
    |=> status[`STAT_EDGE0_BIT])
    else $error("edge 0 not latched");

  AST_MOTOR: assert property (
    @(posedge pclk) disable iff (!presetn)
    sel22 == `ALT_SEL_C && !dir_vec[5] && !od_vec[5]
    |=> pad_out[5] ==
        ($past(unit_drive.floppy_motor_select_1_n) ^ $past(pol_vec[5])))
    else $error("motor select not on pin");

  AST_RSVD_TWO: assert property (
    @(posedge pclk) disable iff (!presetn)
    commit && !pwrite && cfg_hit[4] |-> prdata[6:4] == 3'h0)
    else $error("two-bit reserved bits read nonzero");

endmodule

// file: gpio_pin_far_side.sv
// far side model: pins that show an outside level when released, and the alternate-function units
`timescale 1ns/100ps

module gpio_pin_far_side
  import gpio_pin_pkg::*;
(
  input  wire logic [7:0]  pad_out,
  input  wire logic [7:0]  pad_oe,
  input  wire logic [7:0]  ext_lvl,
  input  wire unit_drive_s drv_cmd,
  output logic      [7:0]  pad_in,
  output unit_drive_s      unit_drive
);
  // ----------------------------------------------------------------
  // pin levels
  // ----------------------------------------------------------------
  // released pin shows the outside level, never the last driven one
  assign pad_in     = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
  assign unit_drive = drv_cmd;
endmodule

// file: gpio_pin_config_bank_tb.sv
// testbench of the pin configuration bank over its register bus
`timescale 1ns/100ps
`include "gpio_pin_config_bank_regs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end

module gpio_pin_config_bank_tb;
  import gpio_pin_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [7:0]  pad_in, pad_out, pad_oe, ext_lvl;
  logic        rerr;
  unit_drive_s unit_drive, drv_cmd;
  unit_sense_s unit_sense;
  int          err_total, n_compared;
  logic [7:0]  idx_t[8] = '{`GPIO_1_5_CONFIG_IDX, `GPIO_1_6_CONFIG_IDX,
    `GPIO_1_7_CONFIG_IDX, `GPIO_2_0_CONFIG_IDX, `GPIO_2_1_CONFIG_IDX,
    `GPIO_2_2_CONFIG_IDX, `GPIO_2_4_CONFIG_IDX, `GPIO_2_5_CONFIG_IDX};
  logic [7:0]  wm_t[8] = '{8'h87, 8'h87, 8'h87, 8'h8F, 8'h8F, 8'h8F, 8'h83,
    8'h87};
  // pin case table: config, data bit, pad level, enable
  logic [7:0]  pc_cfg[4] = '{8'h00, 8'h02, 8'h80, 8'h80};
  logic        pc_dat[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  logic        pc_out[4] = '{1'b1, 1'b0, 1'b0, 1'b0};
  logic        pc_oe[4]  = '{1'b1, 1'b1, 1'b1, 1'b0};
  // alternate output table: slot, config, unit drive bit
  int          ao_slot[5] = '{3, 3, 4, 5, 5};
  logic [7:0]  ao_cfg[5]  = '{8'h08, 8'h04, 8'h04, 8'h04, 8'h0C};
  int          ao_bit[5]  = '{1, 4, 3, 2, 0};

  gpio_pin_config_bank #(.ADDR_WIDTH(12)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .unit_drive(unit_drive),
    .unit_sense(unit_sense), .irq(irq));

  gpio_pin_far_side far (
    .pad_out(pad_out), .pad_oe(pad_oe), .ext_lvl(ext_lvl),
    .drv_cmd(drv_cmd), .pad_in(pad_in), .unit_drive(unit_drive));

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no fixed wait: the watchdog bounds a missing answer
    forever begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rdat    = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 32'h0);
    `CHK(rdat, e)
  endtask

  task automatic settle();
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; ext_lvl = 8'hFF; drv_cmd = '1;
    err_total = 0; n_compared = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd_chk(idx_t[i], 32'h01);
    `CHK(irq, 1'b0)
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, idx_t[i], 32'hFFFF_FFFF);
      rd_chk(idx_t[i], {24'h0, wm_t[i]});
      apb(1'b1, idx_t[i], 32'h01);
    end
    // gap at pin 2.3 is not mapped
    rd_chk(8'h2E, 32'h0);
    `CHK(rerr, 1'b1)
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, idx_t[6], {24'h0, pc_cfg[i]});
      apb(1'b1, `GPIO_DATA_IDX, {25'h0, pc_dat[i], 6'h0});
      settle();
      `CHK(pad_out[6], pc_out[i])
      `CHK(pad_oe[6], pc_oe[i])
    end
    apb(1'b1, idx_t[6], 32'h01);
    settle();
    `CHK(pad_oe[6], 1'b0)
    rd_chk(`GPIO_DATA_IDX, 32'hFF);
    apb(1'b1, idx_t[6], 32'h03);
    rd_chk(`GPIO_DATA_IDX, 32'hBF);
    $display("test pins done");
    @(posedge pclk);
    ext_lvl <= 8'h00;
    settle();
    `CHK(unit_sense.joystick1_y_axis, 1'b0)
    `CHK(unit_sense.music_serial_receive, 1'b1)
    `CHK(unit_sense.interrupt_request_6_input, 1'b0)
    for (int i = 0; i < 8; i++) apb(1'b1, idx_t[i], 32'h05);
    settle();
    `CHK(unit_sense.kbc_port_bit6, 1'b0)
    apb(1'b1, idx_t[4], 32'h0D);
    settle();
    `CHK(unit_sense.music_serial_receive, 1'b0)
    `CHK(unit_sense.joystick2_x_axis, 1'b0)
    `CHK(unit_sense.kbc_port_bit7, 1'b0)
    `CHK(unit_sense.kbc_port_bit2, 1'b0)
    `CHK(unit_sense.kbc_port_bit6, 1'b1)
    @(posedge pclk);
    ext_lvl <= 8'hFF;
    settle();
    `CHK(unit_sense.joystick1_y_axis, 1'b1)
    `CHK(unit_sense.joystick2_x_axis, 1'b1)
    `CHK(unit_sense.joystick2_y_axis, 1'b1)
    `CHK(unit_sense.interrupt_request_6_input, 1'b1)
    $display("test alternate inputs done");
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, idx_t[ao_slot[i]], {24'h0, ao_cfg[i]});
      drv_cmd <= unit_drive_s'(5'h01 << ao_bit[i]);
      settle();
      `CHK(pad_out[ao_slot[i]], 1'b1)
      @(posedge pclk);
      drv_cmd <= unit_drive_s'(~(5'h01 << ao_bit[i]));
      settle();
      `CHK(pad_out[ao_slot[i]], 1'b0)
      apb(1'b1, idx_t[ao_slot[i]], 32'h01);
    end
    $display("test alternate outputs done");
    apb(1'b1, idx_t[4], 32'h09);
    apb(1'b1, idx_t[5], 32'h09);
    apb(1'b1, `GPIO_MASK_IDX, 32'h01);
    apb(1'b0, `GPIO_STATUS_IDX, 32'h0);
    @(posedge pclk);
    ext_lvl <= 8'hEF;
    settle();
    `CHK(irq, 1'b1)
    rd_chk(`GPIO_STATUS_IDX, 32'h01);
    settle();
    `CHK(irq, 1'b0)
    rd_chk(`GPIO_STATUS_IDX, 32'h00);
    @(posedge pclk);
    ext_lvl <= 8'hCF;
    settle();
    // edge on a masked input leaves the line low
    `CHK(irq, 1'b0)
    rd_chk(`GPIO_STATUS_IDX, 32'h02);
    $display("test interrupts done");
    tally_and_finish();
  end
endmodule
